/* File: core/system_config_pkg.sv */
// Shared constants for the system configuration register bank.
// Assumes a 32-bit register port with byte addresses and one system clock.
package system_config_pkg;

  // ==========================================================
  // Address map
  localparam logic [31:0] CFG_BASE = 32'h4000_4000;
  localparam int OFFSET_W = 8;
  localparam logic [7:0] OFF_CORE0_NMI_MASK = 8'h00;
  localparam logic [7:0] OFF_CORE1_NMI_MASK = 8'h04;
  localparam logic [7:0] OFF_PROC_CONFIG = 8'h08;
  localparam logic [7:0] OFF_BYPASS_LOW = 8'h0C;
  localparam logic [7:0] OFF_BYPASS_HIGH = 8'h10;
  localparam logic [7:0] OFF_DEBUG_OVERRIDE = 8'h14;
  localparam logic [7:0] OFF_MEM_POWER_DOWN = 8'h18;

  // ==========================================================
  // Sizes
  localparam int NUM_CORES = 2;
  localparam int IRQ_W = 32;
  localparam int LOW_PINS = 30;
  localparam int HIGH_PINS = 6;
  localparam int MEM_W = 8;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // Processor configuration fields
  localparam int DAP_W = 4;
  localparam int DAP_LSB_CORE0 = 24;
  localparam int DAP_LSB_CORE1 = 28;
  localparam int HALT_BIT_CORE0 = 0;
  localparam int HALT_BIT_CORE1 = 1;
  localparam logic [3:0] DAP_RST_CORE0 = 4'h0;
  localparam logic [3:0] DAP_RST_CORE1 = 4'h1;
  localparam logic [3:0] DAP_RESERVED_ID = 4'hF;

  // ==========================================================
  // Debug override fields, one group of four bits per core
  localparam int DBG_STRIDE = 4;
  localparam int DBG_SWDO = 0;
  localparam int DBG_SWDI = 1;
  localparam int DBG_SWCLK = 2;
  localparam int DBG_ATTACH = 3;
  localparam logic DBG_ATTACH_RST = 1'b0;
  localparam logic DBG_SWCLK_RST = 1'b1;
  localparam logic DBG_SWDI_RST = 1'b1;

  // ==========================================================
  // Other reset values
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [29:0] BYPASS_LOW_RST = 30'h0000_0000;
  localparam logic [5:0] BYPASS_HIGH_RST = 6'h00;
  localparam logic [7:0] MEM_PD_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

/* File: core/input_sync_path.sv */
// Per-pin input synchroniser with a software bypass and the input register.
// Assumes pin_in is asynchronous; bypass_in comes from the system clock domain.
`timescale 1ns/1ps

module input_sync_path #(
  parameter int WIDTH = 30
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins and control
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] bypass_in,
  // Input register
  output logic [WIDTH-1:0] value_out
);

  // ==========================================================
  // Per-bit path
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      logic meta_r;
      logic stable_r;
      logic value_r;
      wire logic value_nxt;
      // Bypass skips both stages; metastable samples may then reach the core
      assign value_nxt = bypass_in[i] ? pin_in[i] : stable_r;
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
          value_r <= 1'b0;
        end
        else
        begin
          meta_r <= pin_in[i];
          stable_r <= meta_r;
          value_r <= value_nxt;
        end
      end
      assign value_out[i] = value_r;
    end
  endgenerate

endmodule

/* File: core/system_config_bank.sv */
// System configuration register bank for two processor cores.
// Assumes a single-cycle register port, cores on the same clock,
// asynchronous pins and asynchronous external debug pads.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

module system_config_bank (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Interrupt sources and core status
  input wire logic [31:0] irq_in,
  input wire logic [1:0] halted_in,
  output logic [1:0] nmi_out,
  output logic [3:0] core0_debug_instance_id_out,
  output logic [3:0] core1_debug_instance_id_out,
  // Pins towards the single-cycle io block
  input wire logic [35:0] pin_in,
  output logic [35:0] pin_value_out,
  // Debug ports: SWCLK and SWDI from pads to cores, SWDO from cores to pads
  input wire logic [1:0] pad_swclk_in,
  input wire logic [1:0] pad_swdi_in,
  input wire logic [1:0] core_swdo_in,
  output logic [1:0] core_swclk_out,
  output logic [1:0] core_swdi_out,
  output logic [1:0] pad_swdo_out,
  // Memory power control
  output logic [7:0] memory_power_down_out
);

  localparam int NC = system_config_pkg::NUM_CORES;
  localparam int LP = system_config_pkg::LOW_PINS;
  localparam int HP = system_config_pkg::HIGH_PINS;
  localparam int DW = system_config_pkg::DAP_W;

  // ==========================================================
  // Address decode
  wire logic base_hit;
  wire logic [7:0] offset;
  wire logic sel_mask0;
  wire logic sel_mask1;
  wire logic sel_config;
  wire logic sel_byp_low;
  wire logic sel_byp_high;
  wire logic sel_debug;
  wire logic sel_mem;
  wire logic sel_any;

  assign base_hit = addr_in[31:system_config_pkg::OFFSET_W]
    == system_config_pkg::CFG_BASE[31:system_config_pkg::OFFSET_W];
  assign offset = addr_in[system_config_pkg::OFFSET_W-1:0];
  assign sel_mask0 = base_hit && offset == system_config_pkg::OFF_CORE0_NMI_MASK;
  assign sel_mask1 = base_hit && offset == system_config_pkg::OFF_CORE1_NMI_MASK;
  assign sel_config = base_hit && offset == system_config_pkg::OFF_PROC_CONFIG;
  assign sel_byp_low = base_hit && offset == system_config_pkg::OFF_BYPASS_LOW;
  assign sel_byp_high = base_hit && offset == system_config_pkg::OFF_BYPASS_HIGH;
  assign sel_debug = base_hit && offset == system_config_pkg::OFF_DEBUG_OVERRIDE;
  assign sel_mem = base_hit && offset == system_config_pkg::OFF_MEM_POWER_DOWN;
  assign sel_any = sel_mask0 || sel_mask1 || sel_config || sel_byp_low
    || sel_byp_high || sel_debug || sel_mem;

  // ==========================================================
  // Software registers
  logic [31:0] mask0_r;
  logic [31:0] mask1_r;
  logic [DW-1:0] dap0_r;
  logic [DW-1:0] dap1_r;
  logic [LP-1:0] byp_low_r;
  logic [HP-1:0] byp_high_r;
  logic [NC-1:0] attach_r;
  logic [NC-1:0] swclk_r;
  logic [NC-1:0] swdi_r;
  logic [7:0] mem_pd_r;

  // Only documented field bits are stored; everything else is dropped
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mask0_r <= system_config_pkg::MASK_RST;
      mask1_r <= system_config_pkg::MASK_RST;
    end
    else
    begin
      if (wr_in && sel_mask0)
        mask0_r <= wdata_in;
      if (wr_in && sel_mask1)
        mask1_r <= wdata_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dap0_r <= system_config_pkg::DAP_RST_CORE0;
      dap1_r <= system_config_pkg::DAP_RST_CORE1;
    end
    else if (wr_in && sel_config)
    begin
      dap0_r <= wdata_in[system_config_pkg::DAP_LSB_CORE0 +: DW];
      dap1_r <= wdata_in[system_config_pkg::DAP_LSB_CORE1 +: DW];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      byp_low_r <= system_config_pkg::BYPASS_LOW_RST;
      byp_high_r <= system_config_pkg::BYPASS_HIGH_RST;
      mem_pd_r <= system_config_pkg::MEM_PD_RST;
    end
    else
    begin
      if (wr_in && sel_byp_low)
        byp_low_r <= wdata_in[LP-1:0];
      if (wr_in && sel_byp_high)
        byp_high_r <= wdata_in[HP-1:0];
      if (wr_in && sel_mem)
        mem_pd_r <= wdata_in[system_config_pkg::MEM_W-1:0];
    end
  end

  // ==========================================================
  // Per-core logic: NMI gating and debug port override
  logic [NC-1:0] nmi_r;
  logic [NC-1:0] swclk_out_r;
  logic [NC-1:0] swdi_out_r;
  logic [NC-1:0] pad_swdo_r;
  wire logic [31:0] mask_word [NC];

  assign mask_word[0] = mask0_r;
  assign mask_word[1] = mask1_r;

  genvar c;
  generate
    for (c = 0; c < NC; c = c + 1)
    begin : g_core
      localparam int FB = c * system_config_pkg::DBG_STRIDE;
      logic clk_meta_r;
      logic clk_sync_r;
      logic di_meta_r;
      logic di_sync_r;
      wire logic nmi_nxt;
      wire logic swclk_nxt;
      wire logic swdi_nxt;
      wire logic swdo_nxt;

      assign nmi_nxt = |(irq_in & mask_word[c]);
      // Attached: register bits drive the port and the pads see nothing
      assign swclk_nxt = attach_r[c] ? swclk_r[c] : clk_sync_r;
      assign swdi_nxt = attach_r[c] ? swdi_r[c] : di_sync_r;
      assign swdo_nxt = attach_r[c] ? 1'b0 : core_swdo_in[c];

      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          attach_r[c] <= system_config_pkg::DBG_ATTACH_RST;
          swclk_r[c] <= system_config_pkg::DBG_SWCLK_RST;
          swdi_r[c] <= system_config_pkg::DBG_SWDI_RST;
        end
        else if (wr_in && sel_debug)
        begin
          attach_r[c] <= wdata_in[FB + system_config_pkg::DBG_ATTACH];
          swclk_r[c] <= wdata_in[FB + system_config_pkg::DBG_SWCLK];
          swdi_r[c] <= wdata_in[FB + system_config_pkg::DBG_SWDI];
        end
      end

      // Pad levels are asynchronous, so two stages before the selector
      // Stages reset to the idle levels so the core sees no false clock edge after reset
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          clk_meta_r <= system_config_pkg::DBG_SWCLK_RST;
          clk_sync_r <= system_config_pkg::DBG_SWCLK_RST;
          di_meta_r <= system_config_pkg::DBG_SWDI_RST;
          di_sync_r <= system_config_pkg::DBG_SWDI_RST;
        end
        else
        begin
          clk_meta_r <= pad_swclk_in[c];
          clk_sync_r <= clk_meta_r;
          di_meta_r <= pad_swdi_in[c];
          di_sync_r <= di_meta_r;
        end
      end

      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          nmi_r[c] <= 1'b0;
          swclk_out_r[c] <= system_config_pkg::DBG_SWCLK_RST;
          swdi_out_r[c] <= system_config_pkg::DBG_SWDI_RST;
          pad_swdo_r[c] <= 1'b0;
        end
        else
        begin
          nmi_r[c] <= nmi_nxt;
          swclk_out_r[c] <= swclk_nxt;
          swdi_out_r[c] <= swdi_nxt;
          pad_swdo_r[c] <= swdo_nxt;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Pin input synchronisers
  // Synchronised pins take three edges to the input register, bypassed one
  input_sync_path #(
    .WIDTH(LP)
  ) u_sync_low (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(pin_in[LP-1:0]),
    .bypass_in(byp_low_r),
    .value_out(pin_value_out[LP-1:0])
  );

  input_sync_path #(
    .WIDTH(HP)
  ) u_sync_high (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(pin_in[LP+HP-1:LP]),
    .bypass_in(byp_high_r),
    .value_out(pin_value_out[LP+HP-1:LP])
  );

  // ==========================================================
  // Read data assembly
  logic [31:0] config_word;
  logic [31:0] debug_word;
  logic [31:0] read_word;
  logic [31:0] rdata_r;

  always_comb
  begin
    config_word = system_config_pkg::WORD_ZERO;
    config_word[system_config_pkg::DAP_LSB_CORE0 +: DW] = dap0_r;
    config_word[system_config_pkg::DAP_LSB_CORE1 +: DW] = dap1_r;
    config_word[system_config_pkg::HALT_BIT_CORE0] = halted_in[0];
    config_word[system_config_pkg::HALT_BIT_CORE1] = halted_in[1];
  end

  always_comb
  begin
    debug_word = system_config_pkg::WORD_ZERO;
    for (int k = 0; k < NC; k++)
    begin
      debug_word[k * system_config_pkg::DBG_STRIDE + system_config_pkg::DBG_ATTACH] = attach_r[k];
      debug_word[k * system_config_pkg::DBG_STRIDE + system_config_pkg::DBG_SWCLK] = swclk_r[k];
      debug_word[k * system_config_pkg::DBG_STRIDE + system_config_pkg::DBG_SWDI] = swdi_r[k];
      debug_word[k * system_config_pkg::DBG_STRIDE + system_config_pkg::DBG_SWDO] = core_swdo_in[k];
    end
  end

  always_comb
  begin
    read_word = system_config_pkg::WORD_ZERO;
    if (sel_mask0)
      read_word = mask0_r;
    if (sel_mask1)
      read_word = mask1_r;
    if (sel_config)
      read_word = config_word;
    if (sel_byp_low)
      read_word[LP-1:0] = byp_low_r;
    if (sel_byp_high)
      read_word[HP-1:0] = byp_high_r;
    if (sel_debug)
      read_word = debug_word;
    if (sel_mem)
      read_word[system_config_pkg::MEM_W-1:0] = mem_pd_r;
  end

  // Data stand for exactly one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_r <= system_config_pkg::WORD_ZERO;
    else if (rd_in)
      rdata_r <= read_word;
    else
      rdata_r <= system_config_pkg::WORD_ZERO;
  end

  // ==========================================================
  // Outputs
  assign rdata_out = rdata_r;
  assign nmi_out = nmi_r;
  assign core0_debug_instance_id_out = dap0_r;
  assign core1_debug_instance_id_out = dap1_r;
  assign core_swclk_out = swclk_out_r;
  assign core_swdi_out = swdi_out_r;
  assign pad_swdo_out = pad_swdo_r;
  assign memory_power_down_out = mem_pd_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  logic [2:0] byp0_age_r;
  always_ff @(posedge clk_in)
  begin
    if (rst_in || byp_low_r[0])
      byp0_age_r <= 3'h0;
    else if (byp0_age_r != 3'h7)
      byp0_age_r <= byp0_age_r + 3'h1;
  end

  a_nmi_core_gate: assert property (
    ##1 nmi_out == {|$past(irq_in & mask1_r), |$past(irq_in & mask0_r)})
    else $error("nmi output does not follow masked irq");

  a_mask_write_effect: assert property (
    (wr_in && sel_mask1) ##1 !(wr_in && sel_mask1) |=> nmi_out[1] == |($past(irq_in) & $past(wdata_in, 2)))
    else $error("core1 mask write not effective");

  a_dap_write_store: assert property (
    (wr_in && sel_config) |=> core1_debug_instance_id_out == $past(wdata_in[31:28])
      && core0_debug_instance_id_out == $past(wdata_in[27:24]))
    else $error("instance identifier not stored");

  a_halted_read_back: assert property (
    (rd_in && sel_config) |=> rdata_out[1:0] == $past(halted_in) && rdata_out[23:2] == 22'h0)
    else $error("halted bits wrong on read");

  a_bypass_fast_path: assert property (
    byp_low_r[0] ##1 byp_low_r[0] |-> pin_value_out[0] == $past(pin_in[0]))
    else $error("bypassed pin not one cycle");

  a_sync_slow_path: assert property (
    (byp0_age_r >= 3'h4) |-> pin_value_out[0] == $past(pin_in[0], 3))
    else $error("synchronised pin not three cycles");

  a_attach_drives_port: assert property (
    (attach_r[0] && !$past(attach_r[0]) == 1'b0) |=> core_swclk_out[0] == $past(swclk_r[0])
      && pad_swdo_out[0] == 1'b0)
    else $error("attached core not driven from register");

  a_mem_pd_write: assert property (
    (wr_in && sel_mem) |=> memory_power_down_out == $past(wdata_in[7:0]))
    else $error("memory power down not applied");

  a_reserved_read_zero: assert property (
    (rd_in && (sel_byp_high || sel_mem || !sel_any)) |=> rdata_out[31:8] == 24'h0)
    else $error("reserved bits not zero");

  a_read_one_cycle: assert property (
    !rd_in |=> rdata_out == 32'h0)
    else $error("read data held without strobe");

  c_attach_core1: cover property (wr_in && sel_debug && wdata_in[7]);
  c_bypass_high: cover property (wr_in && sel_byp_high && wdata_in[5:0] != 6'h00);
  c_nmi_raised: cover property (nmi_out[0] && nmi_out[1]);
  c_mem_pd_read: cover property ((wr_in && sel_mem) ##1 (rd_in && sel_mem));

endmodule

/* File: tb/core_pair_model.sv */
// Behavioural model of the two processor cores seen from the bank.
// Assumes the cores share the system clock; pads and registers drive their ports.
`timescale 1ns/1ps

module core_pair_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Debug port towards each core
  input wire logic [1:0] swclk_in,
  input wire logic [1:0] swdi_in,
  output logic [1:0] swdo_out,
  // Halt control from the bench and status back
  input wire logic [1:0] halt_req_in,
  output logic [1:0] halted_out
);
  // ==========================================================
  // Debug data capture
  logic [1:0] swclk_r;
  // Data out follows data in on a rising debug clock, so a stalled clock freezes it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      swclk_r <= 2'h3;
      swdo_out <= 2'h0;
      halted_out <= 2'h0;
    end
    else
    begin
      swclk_r <= swclk_in;
      swdo_out <= (swdi_in & swclk_in & ~swclk_r) | (swdo_out & ~(swclk_in & ~swclk_r));
      halted_out <= halt_req_in;
    end
  end
endmodule

/* File: tb/system_config_bank_tb.sv */
// Self-checking bench for the system configuration register bank.
// Assumes the core model stands on the debug and status ports.
`timescale 1ns/1ps

module system_config_bank_tb;
  typedef struct {logic [31:0] addr; logic [31:0] wdata; logic [31:0] rst_exp; logic [31:0] exp;} row_type;
  logic clk_in, rst_in, wr_in, rd_in;
  logic [31:0] addr_in, wdata_in, rdata_out, irq_in;
  logic [1:0] halted_in, halt_req, nmi_out, pad_swclk_in, pad_swdi_in, core_swdo_in;
  logic [1:0] core_swclk_out, core_swdi_out, pad_swdo_out;
  logic [3:0] dap0, dap1;
  logic [35:0] pin_in, pin_value_out;
  logic [7:0] mem_out;
  int mismatches = 0;
  int checks = 0;
  row_type rows [9];

  system_config_bank u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_in(irq_in), .halted_in(halted_in),
    .nmi_out(nmi_out), .core0_debug_instance_id_out(dap0), .core1_debug_instance_id_out(dap1),
    .pin_in(pin_in), .pin_value_out(pin_value_out), .pad_swclk_in(pad_swclk_in), .pad_swdi_in(pad_swdi_in),
    .core_swdo_in(core_swdo_in), .core_swclk_out(core_swclk_out), .core_swdi_out(core_swdi_out),
    .pad_swdo_out(pad_swdo_out), .memory_power_down_out(mem_out));
  core_pair_model u_cores (.clk_in(clk_in), .rst_in(rst_in), .swclk_in(core_swclk_out),
    .swdi_in(core_swdi_out), .swdo_out(core_swdo_in), .halt_req_in(halt_req), .halted_out(halted_in));

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial
  begin
    #(25 * 4000);
    mismatches++;
    end_of_test();
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk("rdata", rdata_out, exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    // Instance id 15 never appears in any write below
    rows = '{'{32'h4000_4000, 32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFF},
             '{32'h4000_4004, 32'hA5A5_A5A5, 32'h0, 32'hA5A5_A5A5},
             '{32'h4000_4008, 32'h23FF_FFFF, 32'h1000_0000, 32'h2300_0000},
             '{32'h4000_400C, 32'hFFFF_FFFF, 32'h0, 32'h3FFF_FFFF},
             '{32'h4000_4010, 32'hFFFF_FFFF, 32'h0, 32'h0000_003F},
             '{32'h4000_4014, 32'hFFFF_FF99, 32'h0000_0066, 32'h0000_0088},
             '{32'h4000_4018, 32'hFFFF_FFFF, 32'h0, 32'h0000_00FF},
             '{32'h4000_401C, 32'hFFFF_FFFF, 32'h0, 32'h0},
             '{32'h4001_4000, 32'h0, 32'h0, 32'h0}};
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 32'h0;
    wdata_in = 32'h0;
    irq_in = 32'h0;
    halt_req = 2'h0;
    pin_in = 36'h0_0000_0000;
    pad_swclk_in = 2'h3;
    pad_swdi_in = 2'h0;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("instance ids", {dap1, dap0}, 8'h10);
    chk("core swclk", core_swclk_out, 2'h3);
    foreach (rows[i]) rd(rows[i].addr, rows[i].rst_exp);
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    rd(32'h4000_4000, 32'hFFFF_FFFF);
    @(posedge clk_in);
    #1;
    chk("rdata idle", rdata_out, 32'h0);
    chk("instance ids", {dap1, dap0}, 8'h23);
    chk("memory power", mem_out, 8'hFF);
    // Interrupt routing, one source at a time
    @(posedge clk_in) irq_in <= 32'h0000_0002;
    @(posedge clk_in);
    #1;
    chk("nmi", nmi_out, 2'h1);
    @(posedge clk_in) irq_in <= 32'h0000_0001;
    @(posedge clk_in);
    #1;
    chk("nmi", nmi_out, 2'h3);
    @(posedge clk_in) irq_in <= 32'h8000_0000;
    @(posedge clk_in);
    #1;
    chk("nmi", nmi_out, 2'h3);
    wr(32'h4000_4000, 32'h7FFF_FFFF);
    @(posedge clk_in);
    #1;
    chk("nmi", nmi_out, 2'h2);
    // Halted status is live
    @(posedge clk_in) halt_req <= 2'h2;
    repeat (3) @(posedge clk_in);
    rd(32'h4000_4008, 32'h2300_0002);
    wr(32'h4000_4008, 32'h2300_0001);
    rd(32'h4000_4008, 32'h2300_0002);
    // Bypass only pins 0 and 35; the rest keep the two-stage synchroniser
    wr(32'h4000_400C, 32'h0000_0001);
    wr(32'h4000_4010, 32'h0000_0020);
    pin_in <= 36'h5_A5A5_A5A5;
    repeat (4) @(posedge clk_in);
    pin_in <= 36'hA_5A5A_5A5A;
    repeat (2)
    begin
      @(posedge clk_in);
      #1;
      chk("pin value", pin_value_out, 36'hD_A5A5_A5A4);
    end
    @(posedge clk_in);
    #1;
    chk("pin value", pin_value_out, 36'hA_5A5A_5A5A);
    // Debug ports from the pads, then from the register
    wr(32'h4000_4014, 32'h0000_0000);
    @(posedge clk_in) pad_swclk_in <= 2'h2;
    repeat (2) @(posedge clk_in);
    #1;
    chk("core swclk", core_swclk_out, 2'h3);
    @(posedge clk_in);
    #1;
    chk("core swclk", core_swclk_out, 2'h2);
    @(posedge clk_in) pad_swclk_in <= 2'h3;
    repeat (4) @(posedge clk_in);
    wr(32'h4000_4014, 32'h0000_0008);
    @(posedge clk_in);
    #1;
    chk("core swclk", core_swclk_out, 2'h2);
    wr(32'h4000_4014, 32'h0000_000E);
    repeat (3) @(posedge clk_in);
    rd(32'h4000_4014, 32'h0000_000F);
    chk("pad swdo", pad_swdo_out, 2'h0);
    chk("core swdi", core_swdi_out, 2'h1);
    wr(32'h4000_4014, 32'h0000_0006);
    @(posedge clk_in);
    #1;
    chk("pad swdo", pad_swdo_out, 2'h1);
    // Second reset in mid-run with traffic on the inputs
    @(posedge clk_in);
    halt_req <= 2'h0;
    irq_in <= 32'hFFFF_FFFF;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("nmi", nmi_out, 2'h0);
    chk("memory power", mem_out, 8'h00);
    chk("instance ids", {dap1, dap0}, 8'h10);
    foreach (rows[i]) rd(rows[i].addr, rows[i].rst_exp);
    end_of_test();
  end
endmodule
